// File: hw/window0_pkg.sv
// constants for the target memory window 0 register block
package window0_pkg;
   localparam logic [15:0] BUS_BASE_OFS = 16'hD180;
   localparam logic [15:0] CONTROL_OFS = 16'hD184;
   localparam int BASE_LSB = 20;
   localparam int BASE_MSB = 31;
   localparam int MASK_LSB = 20;
   localparam int MASK_MSB = 28;
   localparam int BURST_LSB = 8;
   localparam int BURST_MSB = 10;
   localparam int FLUSH_BIT = 4;
   localparam int RSVD3_BIT = 3;
   localparam int PREFETCH_BIT = 2;
   localparam int ENABLE_BIT = 1;
   localparam int SWAP_BIT = 0;
   localparam logic [11:0] BASE_RESET = 12'h000;
   localparam logic [8:0] MASK_RESET = 9'h03F;
   localparam logic [2:0] BURST_RESET = 3'h3;
   localparam logic PREFETCH_RESET = 1'b1;
   localparam logic ENABLE_RESET = 1'b0;
   localparam logic [31:0] BASE_WMASK = 32'hFFF00000;
   localparam logic [31:0] CTRL_WMASK = 32'h1FF00707;
   localparam logic [5:0] WORDS_1 = 6'h01;
   localparam logic [5:0] WORDS_4 = 6'h04;
   localparam logic [5:0] WORDS_8 = 6'h08;
   localparam logic [5:0] WORDS_16 = 6'h10;
   localparam logic [5:0] WORDS_32 = 6'h20;
   localparam logic [2:0] CODE_1 = 3'h0;
   localparam logic [2:0] CODE_4 = 3'h1;
   localparam logic [2:0] CODE_8 = 3'h2;
   localparam logic [2:0] CODE_16 = 3'h3;
   localparam logic [2:0] CODE_32 = 3'h4;
   localparam logic [15:0] ADDR_MASK = 16'hFFFC;
endpackage : window0_pkg

// File: hw/window0_regs.sv
// window 0 base and control registers with APB slave and outputs
// Behaviour
// [R1] base field 31:20 is the internal bus base for window 0 accesses
// [R2] mask field 28:20 picks compared address bits, resets to 0x03F
// [R3] burst field 10:8 sets words read: 1,4,8,16,32; resets to 3
// [R4] writing one to bit 4 flushes the window cache, bit self-clears
// [R5] prefetch bit 2 on prefetches; off does one burst; resets to one
// [R6] prefetch bit changes leave configuration prefetchable flag untouched
// [R7] software should keep prefetch default in satellite mode
// [R8] enable bit 1 makes window valid when one; resets to zero
// [R9] disabled window ignores config base writes and reads them as zero
// [R10] swap bit 0 enables byte swap; resets by endian mode
// [R11] big-endian with swap clear keeps 32-bit word byte order
// [R12] software keeps reserved bit 3 at zero
// [R13] reserved bits read zero and ignore writes
module window0_regs
   import window0_pkg::*;
#(
   parameter int SYNC_STAGES = 2
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic big_endian,
   input wire logic cfg_bar_wr,
   input wire logic [31:0] cfg_bar_wdata,
   input wire logic cfg_bar_prefetchable,
   output logic [31:0] cfg_bar_rdata,
   output logic [11:0] bus_base,
   output logic [8:0] compare_mask_field,
   output logic [2:0] read_burst_size,
   output logic [5:0] burst_words,
   output logic window_cache_flush,
   output logic window_prefetch_on,
   output logic window_enable_bit,
   output logic byte_order_swap,
   output logic swap_lanes
);
   // strap sample point: edges after release until the chain is full
   localparam logic [3:0] LOAD_AT = 4'(SYNC_STAGES);

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_ACCESS = 2'b10
   } apb_state_t;

   apb_state_t state_q;
   apb_state_t state_d;
   logic endian_sync_q [SYNC_STAGES];
   logic endian_s;
   logic [3:0] init_cnt_q;
   logic strap_load;
   logic [11:0] base_q;
   logic [8:0] mask_q;
   logic [2:0] burst_q;
   logic prefetch_q;
   logic enable_q;
   logic swap_q;
   logic [31:0] bar_q;
   logic [31:0] base_word;
   logic [31:0] ctrl_word;
   logic [31:0] base_next;
   logic [31:0] ctrl_next;
   logic [31:0] wmask;
   logic apb_setup;
   logic apb_write;
   logic base_wr;
   logic ctrl_wr;
   logic flush_req;

   // refuse synchroniser chain lengths outside 2 to 8
   if (SYNC_STAGES < 2 || SYNC_STAGES > 8) begin : g_bad_sync
      $error("SYNC_STAGES must lie between 2 and 8");
   end

   // burst code to word count
   function automatic logic [5:0] words_of(input logic [2:0] code);
      case (code)
         CODE_1: words_of = WORDS_1;
         CODE_4: words_of = WORDS_4;
         CODE_8: words_of = WORDS_8;
         CODE_16: words_of = WORDS_16;
         CODE_32: words_of = WORDS_32;
         default: words_of = WORDS_1;
      endcase
   endfunction : words_of

   // byte strobes into a bit mask
   function automatic logic [31:0] lane_mask(input logic [3:0] s);
      lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction : lane_mask

   // register select from a byte address
   function automatic logic hits(input logic [15:0] a,
                                 input logic [15:0] ofs);
      hits = (a & ADDR_MASK) == ofs;
   endfunction : hits

   // keep old bits outside the mask, take new ones inside
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [31:0] m);
      merge = (old_v & ~m) | (new_v & m);
   endfunction : merge

   assign apb_setup = psel && !penable;
   assign apb_write = psel && penable && pwrite && state_q == ST_ACCESS;
   assign base_wr = apb_write && hits(paddr, BUS_BASE_OFS);
   assign ctrl_wr = apb_write && hits(paddr, CONTROL_OFS);
   assign wmask = lane_mask(pstrb);
   assign base_word = {base_q, {BASE_LSB{1'b0}}}; // R13
   assign base_next = merge(base_word, pwdata, wmask & BASE_WMASK); // R13
   assign ctrl_next = merge(ctrl_word, pwdata, wmask & CTRL_WMASK); // R13
   assign flush_req = ctrl_wr && wmask[FLUSH_BIT] && pwdata[FLUSH_BIT];
   assign endian_s = endian_sync_q[SYNC_STAGES-1];
   assign strap_load = init_cnt_q == LOAD_AT;

   // control word as software sees it; bits 3 and 4 read zero
   always_comb begin
      ctrl_word = '0;
      ctrl_word[MASK_MSB:MASK_LSB] = mask_q;
      ctrl_word[BURST_MSB:BURST_LSB] = burst_q;
      ctrl_word[PREFETCH_BIT] = prefetch_q;
      ctrl_word[ENABLE_BIT] = enable_q;
      ctrl_word[SWAP_BIT] = swap_q;
   end

   // apb phase state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   always_comb begin
      state_d = ST_IDLE;
      case (state_q)
         ST_IDLE: begin
            if (apb_setup) begin
               state_d = ST_ACCESS;
            end
         end
         ST_ACCESS: begin
            if (apb_setup) begin
               state_d = ST_ACCESS;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // endian strap synchroniser, first stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         endian_sync_q[0] <= 1'b0;
      end else begin
         endian_sync_q[0] <= big_endian;
      end
   end

   // remaining synchroniser stages
   for (genvar g = 1; g < SYNC_STAGES; g++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            endian_sync_q[g] <= 1'b0;
         end else begin
            endian_sync_q[g] <= endian_sync_q[g-1];
         end
      end
   end

   // counts edges after release so the swap default waits for the strap
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         init_cnt_q <= '0;
      end else if (init_cnt_q <= LOAD_AT) begin
         init_cnt_q <= init_cnt_q + 4'h1;
      end
   end

   // base field
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         base_q <= BASE_RESET;
      end else if (base_wr) begin
         base_q <= base_next[BASE_MSB:BASE_LSB]; // R1
      end
   end

   // compare mask field
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q <= MASK_RESET; // R2
      end else if (ctrl_wr) begin
         mask_q <= ctrl_next[MASK_MSB:MASK_LSB]; // R2
      end
   end

   // read burst size code
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         burst_q <= BURST_RESET; // R3
      end else if (ctrl_wr) begin
         burst_q <= ctrl_next[BURST_MSB:BURST_LSB]; // R3
      end
   end

   // prefetch enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prefetch_q <= PREFETCH_RESET; // R5
      end else if (ctrl_wr) begin
         prefetch_q <= ctrl_next[PREFETCH_BIT]; // R5
      end
   end

   // window enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable_q <= ENABLE_RESET; // R8
      end else if (ctrl_wr) begin
         enable_q <= ctrl_next[ENABLE_BIT]; // R8
      end
   end

   // byte swap: default follows the synchronised strap, a write wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         swap_q <= 1'b0;
      end else if (ctrl_wr) begin
         swap_q <= ctrl_next[SWAP_BIT]; // R10
      end else if (strap_load) begin
         swap_q <= endian_s; // R10
      end
   end

   // flush pulse: write of one self-clears next cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         window_cache_flush <= 1'b0;
      end else begin
         window_cache_flush <= flush_req; // R4
      end
   end

   // configuration space base register of window 0
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bar_q <= '0;
      end else if (cfg_bar_wr && enable_q) begin
         bar_q <= cfg_bar_wdata; // R9
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_bar_rdata <= '0;
      end else if (!enable_q) begin
         cfg_bar_rdata <= '0; // R9
      end else begin
         // prefetchable flag is external, never the prefetch bit
         cfg_bar_rdata <= {bar_q[31:4], cfg_bar_prefetchable,
                           bar_q[2:0]}; // R6
      end
   end

   // registered copies of the fields for the bridge datapath
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_base <= BASE_RESET;
         compare_mask_field <= MASK_RESET;
         read_burst_size <= BURST_RESET;
         burst_words <= WORDS_16;
         window_prefetch_on <= PREFETCH_RESET;
         window_enable_bit <= ENABLE_RESET;
         byte_order_swap <= 1'b0;
         swap_lanes <= 1'b0;
      end else begin
         bus_base <= base_q; // R1
         compare_mask_field <= mask_q; // R2
         read_burst_size <= burst_q;
         burst_words <= words_of(burst_q); // R3
         window_prefetch_on <= prefetch_q; // R5
         window_enable_bit <= enable_q; // R8
         byte_order_swap <= swap_q; // R10
         // big-endian core: word lanes need swap either way
         swap_lanes <= swap_q || endian_s; // R11
      end
   end

   // apb ready: zero wait, high in the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= state_d == ST_ACCESS;
      end
   end

   // read data and error, decoded in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
         pslverr <= 1'b0;
      end else if (apb_setup) begin
         if (hits(paddr, BUS_BASE_OFS)) begin
            prdata <= base_word; // R13
            pslverr <= 1'b0;
         end else if (hits(paddr, CONTROL_OFS)) begin
            prdata <= ctrl_word; // R13
            pslverr <= 1'b0;
         end else begin
            prdata <= '0;
            pslverr <= 1'b1;
         end
      end else begin
         prdata <= '0;
         pslverr <= 1'b0;
      end
   end
endmodule : window0_regs

// File: tb/window0_regs_monitor.sv
// assertion checker for the window 0 register block
module window0_regs_monitor
   import window0_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic cfg_bar_prefetchable,
   input wire logic [31:0] cfg_bar_rdata,
   input wire logic [2:0] read_burst_size,
   input wire logic [5:0] burst_words,
   input wire logic window_cache_flush,
   input wire logic window_enable_bit,
   input wire logic byte_order_swap,
   input wire logic swap_lanes
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic ctl = paddr == CONTROL_OFS;
   wire logic map = ctl || paddr == BUS_BASE_OFS;
   property p_rdy; psel && !penable |=> pready; endproperty
   a_rdy: assert property (p_rdy) else $error("no ready after setup");
   property p_fl; psel && penable && pwrite && ctl && pwdata[4] && pstrb[0]
      |=> window_cache_flush ##1 !window_cache_flush; endproperty
   a_fl: assert property (p_fl) else $error("bad flush pulse");
   property p_wd; burst_words == (read_burst_size inside {[1:4]} ?
      6'(2 << read_burst_size) : WORDS_1); endproperty
   a_wd: assert property (p_wd) else $error("bad burst words");
   property p_b0; !window_enable_bit && !$past(window_enable_bit)
      |-> cfg_bar_rdata == '0; endproperty
   a_b0: assert property (p_b0) else $error("bar not zero");
   property p_er; pready |-> pslverr == !map; endproperty
   a_er: assert property (p_er) else $error("bad slave error");
   property p_rs; pready && !pwrite && ctl
      |-> (prdata & ~CTRL_WMASK) == '0; endproperty
   a_rs: assert property (p_rs) else $error("reserved bits set");
   property p_sw; byte_order_swap |-> swap_lanes; endproperty
   a_sw: assert property (p_sw) else $error("swap lanes off");
   property p_pf; window_enable_bit && $past(window_enable_bit)
      |-> cfg_bar_rdata[3] == cfg_bar_prefetchable; endproperty
   a_pf: assert property (p_pf) else $error("bar flag changed");
   c_fl: cover property (window_cache_flush);
   c_er: cover property (pready && pslverr);
   c_en: cover property (window_enable_bit && cfg_bar_rdata[3]);
endmodule : window0_regs_monitor

// File: tb/pci_initiator_model.sv
// behavioural initiator writing the window 0 config base register
module pci_initiator_model (
   output logic cfg_bar_wr,
   output logic [31:0] cfg_bar_wdata,
   output logic cfg_bar_prefetchable,
   input wire logic pclk
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      cfg_bar_wr = 1'b0;
      cfg_bar_wdata = 32'h0;
      cfg_bar_prefetchable = 1'b1;
   end
   task bar_write(input logic [31:0] d);
      @(posedge pclk);
      cfg_bar_wr <= 1'b1;
      cfg_bar_wdata <= d;
      @(posedge pclk);
      cfg_bar_wr <= 1'b0;
      cfg_bar_wdata <= ~d;
   endtask : bar_write
endmodule : pci_initiator_model

// File: tb/pci_target_memory_window0_bench.sv
// self-checking bench for the window 0 register block
module pci_target_memory_window0_bench;
   import window0_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [15:0] paddr = 16'h0;
   logic [31:0] pwdata = 32'h0, prdata, cfg_bar_wdata, cfg_bar_rdata, rd;
   logic [3:0] pstrb = 4'hF;
   logic big_endian = 1'b0;
   logic pready, pslverr, cfg_bar_wr, cfg_bar_prefetchable, err;
   logic [11:0] bus_base;
   logic [8:0] compare_mask_field;
   logic [2:0] read_burst_size;
   logic [5:0] burst_words;
   logic window_cache_flush, window_prefetch_on, window_enable_bit;
   logic byte_order_swap, swap_lanes;
   int error_cnt = 0, checks = 0, cyc = 0, flushes = 0;
   logic [5:0] words [5] = '{6'h01, 6'h04, 6'h08, 6'h10, 6'h20};
   window0_regs uut (.*);
   pci_initiator_model pi (.*);
   initial begin
      forever #10 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      if (window_cache_flush === 1'b1) begin
         flushes++;
      end
      if (cyc == 2000) begin
         error_cnt++;
         end_sim;
      end
   end
   task chk(input string n, input logic [31:0] s, input logic [31:0] x);
      checks++;
      if (s !== x) begin
         error_cnt++;
         $display("CHECK FAILED %s exp %h got %h", n, x, s);
      end
   endtask : chk
   task xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask : xfer
   task end_sim;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_sim
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      xfer(0, BUS_BASE_OFS, 0);
      chk("base rst", rd, 32'h0);
      xfer(0, CONTROL_OFS, 0);
      chk("ctrl rst", rd, 32'h03F00304);
      xfer(1, BUS_BASE_OFS, 32'hFFFFFFFF);
      xfer(0, BUS_BASE_OFS, 0);
      chk("base rw", rd, BASE_WMASK);
      chk("bus base", bus_base, 12'hFFF);
      pstrb <= 4'h1;
      xfer(1, BUS_BASE_OFS, 32'h0);
      pstrb <= 4'hF;
      xfer(0, BUS_BASE_OFS, 0);
      chk("strobe", rd, BASE_WMASK);
      for (int i = 0; i < 5; i++) begin
         xfer(1, CONTROL_OFS, 32'h1FF00013 | 32'(i) << 8);
         xfer(0, CONTROL_OFS, 0);
         chk("ctrl rw", rd, 32'h1FF00003 | 32'(i) << 8);
         chk("words", burst_words, words[i]);
         chk("burst code", read_burst_size, 32'(i));
         chk("enable", window_enable_bit, 1);
      end
      chk("flushes", flushes, 5);
      chk("mask", compare_mask_field, 9'h1FF);
      chk("prefetch", window_prefetch_on, 0);
      xfer(1, CONTROL_OFS, 32'h0);
      pi.bar_write(32'hFFFFFFF0);
      repeat (2) @(posedge pclk);
      chk("bar off", cfg_bar_rdata, 0);
      xfer(1, CONTROL_OFS, 32'h2);
      chk("bar flag", cfg_bar_rdata[3], 1);
      pi.bar_write(32'hFFFFFFF0);
      repeat (2) @(posedge pclk);
      chk("bar on", cfg_bar_rdata, 32'hFFFFFFF8);
      xfer(0, 16'hD190, 0);
      chk("unmapped", {err, rd[30:0]}, 32'h80000000);
      big_endian <= 1'b1;
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      xfer(0, CONTROL_OFS, 0);
      chk("ctrl be rst", rd, 32'h03F00305);
      chk("swap be", byte_order_swap, 1);
      xfer(1, CONTROL_OFS, 32'h03F00304);
      chk("swap off", byte_order_swap, 0);
      chk("lanes be", swap_lanes, 1);
      end_sim;
   end
endmodule : pci_target_memory_window0_bench
bind window0_regs window0_regs_monitor mon (.*);
